// *** inc/mps_defs.vh ***
/*
 * Constants for the motor protection sequencer: register offsets, field
 * positions, reset values and timing figures. Assumes a 250 MHz clk_sys.
 */
`ifndef MPS_DEFS_VH
`define MPS_DEFS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MPS_A_CTRL 8'h00
`define MPS_A_ISET 8'h04
`define MPS_A_OLT 8'h08
`define MPS_A_GF 8'h0C
`define MPS_A_SEQT 8'h10
`define MPS_A_CMPT 8'h14
`define MPS_A_STAT 8'h18
`define MPS_A_THERM 8'h1C
`define MPS_A_FLTA 8'h20
`define MPS_A_FLTB 8'h24
`define MPS_A_FLTC 8'h28
`define MPS_A_HIST 8'h2C
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define MPS_C_DEF 0
`define MPS_C_PHEN 1
`define MPS_C_REVEN 2
`define MPS_C_GFEN 3
`define MPS_C_UCEN 4
`define MPS_C_MODE_LO 5
`define MPS_C_BAUD_LO 8
`define MPS_C_FRST 12
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MPS_R_CTRL 32'h0000_0000
`define MPS_R_ISET 32'h0030_0064
`define MPS_R_OLT 32'h003C_C83C
`define MPS_R_GF 32'h0005_0064
`define MPS_R_SEQT 32'h0000_0000
`define MPS_R_CMPT 32'h0000_0000
// ----------------------------------------
// Timing, in milliseconds unless noted
// ----------------------------------------
`define MPS_CLK_HZ 250000000
`define MPS_T_UC_MS 3000
`define MPS_T_OPEN_MS 1500
`define MPS_T_UNB_MS 5000
`define MPS_T_REV_MS 100
`define MPS_GF_STEP_MS 10
`endif

// *** logic/mps_top.v ***
/*
 * Motor protection and start sequencer with a classic Wishbone slave.
 * Assumes phase and zero-sequence currents arrive as samples on clk_sys;
 * operator pins, flow switch, external trip and phase signs are async.
 */
// Summary of operation
// R01: I-squared-t estimate accumulates; overload trip at full thermal capacity.
// R02: Inverse curve time at six times set current is 1 to 60 s.
// R03: Definite mode waits delay time, then trips on overcurrent beyond operate time.
// R04: Under-current threshold 30 to 70 percent; trip within 3 s.
// R05: Imbalance ratio 70 percent or more is open phase; trip within 1.5 s.
// R06: Imbalance ratio 30 to 50 percent is unbalance; trip within 5 s.
// R07: Open phase and unbalance can be OFF; set OFF for single phase.
// R08: Reversed phase sequence trips within 0.1 s.
// R09: Reverse check only while running and above 110 percent minimum current.
// R10: Ground fault 100 to 2500 mA, delay 0.05 to 1.0 s, separate sensor.
// R11: Software turns ground fault off when inverter start is used.
// R12: Fault currents per phase by up/down keys; history by escape plus enter.
// R13: Time-delay mode closes contactor after on-delay following ON.
// R14: Time-delay mode opens contactor after off-delay following OFF.
// R15: External trip latches with message; released after input removed and reset.
// R16: Flow mode closes after on-delay if flow appears within the window.
// R17: No flow within window cancels start, shows flow timeout, stays open.
// R18: Flow lost while running opens at once; restarts if flow returns in time.
// R19: Flow mode OFF opens contactor after off-delay.
// R20: Software sets compare timer larger than on-delay.
// R21: Remote link is half-duplex RTU at 9600, 19200 or 38400 bit/s.
// R22: Any trip drives fault output; cause latched until reset and condition gone.
`include "mps_defs.vh"
`default_nettype none
module mps_top #(
	parameter MS_CYC = `MPS_CLK_HZ / 1000,
	parameter MIN_CUR = 16'd10
) (
	input wire clk_sys,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [15:0] cur_a,
	input wire [15:0] cur_b,
	input wire [15:0] cur_c,
	input wire [11:0] zero_sequence_sensor,
	input wire sign_a,
	input wire sign_b,
	input wire sign_c,
	input wire on_cmd,
	input wire off_cmd,
	input wire flow_sw,
	input wire ext_trip2,
	input wire key_up,
	input wire key_down,
	input wire escape_key,
	input wire enter_key,
	output reg main_contactor,
	output reg fault_out,
	output reg flow_timeout_message,
	output reg ext_trip_message,
	output reg [15:0] disp_value,
	output reg disp_history,
	output reg [15:0] baud_div
);
	localparam S_IDLE = 5'b00001;
	localparam S_ONW = 5'b00010;
	localparam S_RUN = 5'b00100;
	localparam S_OFFW = 5'b01000;
	localparam S_LOST = 5'b10000;

	// Scale a one-second setting into milliseconds
	function [17:0] sec_ms;
		input [8:0] s;
		begin
			sec_ms = s * 18'd1000;
		end
	endfunction

	reg [31:0] ctrl_ff, iset_ff, olt_ff, gf_ff, seqt_ff, cmpt_ff;
	reg [11:0] sy1_ff, sy2_ff, syp_ff;
	reg [17:0] tick_cnt_ff;
	reg tick_ff;
	reg [55:0] acc_ff;
	reg [17:0] dtm_ff;
	reg [17:0] pt_ff [0:5];
	reg [6:0] cause_ff;
	reg [1:0] last_ff;
	reg rev_ff;
	reg [4:0] st_ff;
	reg [17:0] tdly_ff, tcmp_ff;
	reg [15:0] flt_ff [0:2];
	reg [7:0] hist_ff [0:3];
	reg [1:0] sel_ff;
	integer i, j, k;

	wire [11:0] sy = sy2_ff;
	wire on_p = sy[0] & ~syp_ff[0];
	wire off_p = sy[1] & ~syp_ff[1];
	wire flow = sy[2];
	wire ext = sy[3];
	wire up_p = sy[4] & ~syp_ff[4];
	wire dn_p = sy[5] & ~syp_ff[5];
	wire hist_k = sy[6] & sy[7];
	wire ra = sy[8] & ~syp_ff[8];
	wire rb = sy[9] & ~syp_ff[9];
	wire rc = sy[10] & ~syp_ff[10];
	wire [1:0] mode = ctrl_ff[`MPS_C_MODE_LO+1:`MPS_C_MODE_LO];
	wire [15:0] iset = iset_ff[15:0];
	wire bus = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = bus & wb_we_i;
	wire frst = wr & (wb_adr_i == `MPS_A_CTRL) & wb_sel_i[1] & wb_dat_i[`MPS_C_FRST];

	// ----------------------------------------
	// Current evaluation
	// ----------------------------------------
	wire [15:0] mx1 = (cur_a > cur_b) ? cur_a : cur_b;
	wire [15:0] imax = (mx1 > cur_c) ? mx1 : cur_c;
	wire [15:0] mn1 = (cur_a < cur_b) ? cur_a : cur_b;
	wire [15:0] imin = (mn1 < cur_c) ? mn1 : cur_c;
	wire [23:0] dif100 = (imax - imin) * 24'd100;
	wire [23:0] max70 = imax * 24'd70;
	wire [23:0] max50 = imax * 24'd50;
	wire [23:0] max30 = imax * 24'd30;
	wire [31:0] isq = imax * imax;
	wire [31:0] ssq = iset * iset;
	wire [55:0] cap = ssq * olt_ff[5:0] * 56'd36000; // [R02]
	wire over110 = {4'h0, imax} * 20'd10 > {4'h0, iset} * 20'd11;
	wire over105 = {5'h0, imax} * 21'd100 > {5'h0, iset} * 21'd105;
	wire [23:0] uc_lim = iset * iset_ff[23:16];
	wire run = main_contactor;
	wire live = imax > MIN_CUR;
	wire ol_c = ~ctrl_ff[`MPS_C_DEF] & (acc_ff >= cap); // [R01]
	wire ddone = dtm_ff >= sec_ms({1'b0, olt_ff[15:8]});

	// Conditions and limits of timed protections
	reg [5:0] cond;
	reg [17:0] lim [0:5];
	always @*
	begin
		cond[0] = ctrl_ff[`MPS_C_DEF] & ddone & over105; // [R03]
		cond[1] = ctrl_ff[`MPS_C_UCEN] & run & ({8'h0, imax} * 24'd100 < uc_lim); // [R04]
		cond[2] = ctrl_ff[`MPS_C_PHEN] & live & (dif100 >= max70); // [R05] [R07]
		cond[3] = ctrl_ff[`MPS_C_PHEN] & live & (dif100 >= max30)
			& (dif100 <= max50); // [R06] [R07]
		cond[4] = ctrl_ff[`MPS_C_REVEN] & run & rev_ff
			& ({4'h0, imax} * 20'd10 >= {4'h0, MIN_CUR} * 20'd11); // [R09]
		cond[5] = ctrl_ff[`MPS_C_GFEN]
			& (zero_sequence_sensor >= gf_ff[11:0]); // [R10]
		lim[0] = sec_ms({3'h0, olt_ff[21:16]});
		lim[1] = 18'd`MPS_T_UC_MS;
		lim[2] = 18'd`MPS_T_OPEN_MS;
		lim[3] = 18'd`MPS_T_UNB_MS;
		lim[4] = 18'd`MPS_T_REV_MS; // [R08]
		lim[5] = gf_ff[23:16] * 18'd`MPS_GF_STEP_MS;
	end

	reg [6:0] now;
	always @*
	begin
		now[0] = ol_c;
		for (i = 0; i < 6; i = i + 1)
			now[i+1] = cond[i] & (pt_ff[i] >= lim[i]);
	end
	// Overcurrent of definite mode shares the overload cause bit
	wire [6:0] trip = {ext, now[6], now[5], now[4], now[3], now[2], now[1] | now[0]};
	wire any = |trip;

	// ----------------------------------------
	// Pin synchronisers and ms tick
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			sy1_ff <= 12'h000;
			sy2_ff <= 12'h000;
			syp_ff <= 12'h000;
			tick_cnt_ff <= 18'h0_0000;
			tick_ff <= 1'b0;
		end
		else
		begin
			sy1_ff <= {1'b0, sign_c, sign_b, sign_a, enter_key, escape_key,
				key_down, key_up, ext_trip2, flow_sw, off_cmd, on_cmd};
			sy2_ff <= sy1_ff;
			syp_ff <= sy2_ff;
			tick_ff <= (tick_cnt_ff == MS_CYC - 1);
			tick_cnt_ff <= (tick_cnt_ff == MS_CYC - 1) ? 18'h0_0000 : tick_cnt_ff + 18'h0_0001;
		end
	end

	// ----------------------------------------
	// Protection timing
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			acc_ff <= 56'h0;
			dtm_ff <= 18'h0_0000;
			last_ff <= 2'b00;
			rev_ff <= 1'b0;
			for (j = 0; j < 6; j = j + 1)
				pt_ff[j] <= 18'h0_0000;
		end
		else
		begin
			// Phase order check: A rising right after B means the sequence is reversed
			if (ra)
			begin
				rev_ff <= (last_ff == 2'd1); // [R08]
				last_ff <= 2'd0;
			end
			else if (rb)
				last_ff <= 2'd1;
			else if (rc)
				last_ff <= 2'd2;
			if (tick_ff)
			begin
				// Thermal: heat above 110 percent, cool by rated square below
				if (ctrl_ff[`MPS_C_DEF])
					acc_ff <= 56'h0;
				else if (over110)
					acc_ff <= acc_ff + {24'h0, isq}; // [R01]
				else if (acc_ff >= {24'h0, ssq})
					acc_ff <= acc_ff - {24'h0, ssq};
				else
					acc_ff <= 56'h0;
				// Delay time counts from motor start, ignoring thermal state
				if (!run)
					dtm_ff <= 18'h0_0000;
				else if (!ddone)
					dtm_ff <= dtm_ff + 18'h0_0001; // [R03]
				for (j = 0; j < 6; j = j + 1)
					if (!cond[j])
						pt_ff[j] <= 18'h0_0000;
					else if (pt_ff[j] < lim[j])
						pt_ff[j] <= pt_ff[j] + 18'h0_0001;
			end
		end
	end

	// ----------------------------------------
	// Fault latch, records and display
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			cause_ff <= 7'h00;
			fault_out <= 1'b0;
			ext_trip_message <= 1'b0;
			sel_ff <= 2'd0;
			disp_value <= 16'h0000;
			disp_history <= 1'b0;
			for (k = 0; k < 3; k = k + 1)
				flt_ff[k] <= 16'h0000;
			for (k = 0; k < 4; k = k + 1)
				hist_ff[k] <= 8'h00;
		end
		else
		begin
			// Set wins; reset clears only causes whose condition is gone
			cause_ff <= (cause_ff & ~(frst ? ~trip : 7'h00)) | trip; // [R22] [R15]
			fault_out <= |((cause_ff & ~(frst ? ~trip : 7'h00)) | trip); // [R22]
			ext_trip_message <= (cause_ff[6] & ~(frst & ~ext)) | ext; // [R15]
			if (any & ~(|cause_ff))
			begin
				flt_ff[0] <= cur_a; // [R12]
				flt_ff[1] <= cur_b;
				flt_ff[2] <= cur_c;
				hist_ff[0] <= {1'b0, trip};
				for (k = 1; k < 4; k = k + 1)
					hist_ff[k] <= hist_ff[k-1];
			end
			if (up_p)
				sel_ff <= (sel_ff == 2'd2) ? 2'd0 : sel_ff + 2'd1;
			else if (dn_p)
				sel_ff <= (sel_ff == 2'd0) ? 2'd2 : sel_ff - 2'd1;
			disp_history <= hist_k; // [R12]
			disp_value <= hist_k ? {8'h00, hist_ff[sel_ff]} : flt_ff[sel_ff];
		end
	end

	// ----------------------------------------
	// Contactor sequencing
	// ----------------------------------------
	wire [17:0] on_ms = sec_ms(seqt_ff[8:0]);
	wire [17:0] off_ms = sec_ms(seqt_ff[24:16]);
	wire [17:0] cmp_ms = sec_ms(cmpt_ff[8:0]); // [R20]
	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			st_ff <= S_IDLE;
			main_contactor <= 1'b0;
			flow_timeout_message <= 1'b0;
			tdly_ff <= 18'h0_0000;
			tcmp_ff <= 18'h0_0000;
		end
		else if (any | (|cause_ff))
		begin
			st_ff <= S_IDLE;
			main_contactor <= 1'b0;
		end
		else
		begin
			if (tick_ff)
			begin
				tdly_ff <= tdly_ff + 18'h0_0001;
				tcmp_ff <= tcmp_ff + 18'h0_0001;
			end
			case (st_ff)
			S_IDLE:
				if (on_p)
				begin
					flow_timeout_message <= 1'b0;
					tdly_ff <= 18'h0_0000;
					tcmp_ff <= 18'h0_0000;
					if (mode == 2'd0)
					begin
						main_contactor <= 1'b1;
						st_ff <= S_RUN;
					end
					else
						st_ff <= S_ONW;
				end
			S_ONW:
				if (off_p)
					st_ff <= S_IDLE;
				else if (tdly_ff >= on_ms && (mode != 2'd2 || flow))
				begin
					main_contactor <= 1'b1; // [R13] [R16]
					st_ff <= S_RUN;
				end
				else if (mode == 2'd2 && tcmp_ff >= cmp_ms && !flow)
				begin
					flow_timeout_message <= 1'b1; // [R17]
					st_ff <= S_IDLE;
				end
			S_RUN:
				if (off_p)
				begin
					tdly_ff <= 18'h0_0000;
					if (mode == 2'd0)
					begin
						main_contactor <= 1'b0;
						st_ff <= S_IDLE;
					end
					else
						st_ff <= S_OFFW;
				end
				else if (mode == 2'd2 && !flow)
				begin
					main_contactor <= 1'b0; // [R18]
					tcmp_ff <= 18'h0_0000;
					st_ff <= S_LOST;
				end
			S_OFFW:
				if (tdly_ff >= off_ms)
				begin
					main_contactor <= 1'b0; // [R14] [R19]
					st_ff <= S_IDLE;
				end
			S_LOST:
				if (off_p)
					st_ff <= S_IDLE;
				else if (flow)
				begin
					tdly_ff <= 18'h0_0000;
					tcmp_ff <= 18'h0_0000;
					st_ff <= S_ONW; // [R18]
				end
				else if (tcmp_ff + on_ms >= cmp_ms)
				begin
					flow_timeout_message <= 1'b1; // [R18]
					st_ff <= S_IDLE;
				end
			default:
				st_ff <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Wishbone slave, one wait state
	// ----------------------------------------
	wire [31:0] stat = {16'h0, 3'h0, flow_timeout_message, fault_out,
		main_contactor, st_ff[4:3] != 2'b00, ext, 1'b0, cause_ff};
	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			ctrl_ff <= `MPS_R_CTRL;
			iset_ff <= `MPS_R_ISET;
			olt_ff <= `MPS_R_OLT;
			gf_ff <= `MPS_R_GF;
			seqt_ff <= `MPS_R_SEQT;
			cmpt_ff <= `MPS_R_CMPT;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			baud_div <= 16'h0000;
		end
		else
		begin
			wb_ack_o <= bus;
			// Bit rate divisor for the half-duplex serial link
			if (ctrl_ff[9:8] == 2'd2)
				baud_div <= 16'd6510; // [R21]
			else if (ctrl_ff[9:8] == 2'd1)
				baud_div <= 16'd13020;
			else
				baud_div <= 16'd26041;
			if (wr && wb_adr_i == `MPS_A_CTRL)
				ctrl_ff <= {19'h0, 1'b0, wb_dat_i[11:0]} & 32'h0000_037F;
			else if (wr && wb_adr_i == `MPS_A_ISET)
				iset_ff <= wb_dat_i & 32'h00FF_FFFF;
			else if (wr && wb_adr_i == `MPS_A_OLT)
				olt_ff <= wb_dat_i & 32'h003F_FF3F;
			else if (wr && wb_adr_i == `MPS_A_GF)
				gf_ff <= wb_dat_i & 32'h00FF_0FFF;
			else if (wr && wb_adr_i == `MPS_A_SEQT)
				seqt_ff <= wb_dat_i & 32'h01FF_01FF;
			else if (wr && wb_adr_i == `MPS_A_CMPT)
				cmpt_ff <= wb_dat_i & 32'h0000_01FF;
			if (!bus)
				wb_dat_o <= 32'h0000_0000;
			else if (wb_adr_i == `MPS_A_CTRL)
				wb_dat_o <= ctrl_ff;
			else if (wb_adr_i == `MPS_A_ISET)
				wb_dat_o <= iset_ff;
			else if (wb_adr_i == `MPS_A_OLT)
				wb_dat_o <= olt_ff;
			else if (wb_adr_i == `MPS_A_GF)
				wb_dat_o <= gf_ff;
			else if (wb_adr_i == `MPS_A_SEQT)
				wb_dat_o <= seqt_ff;
			else if (wb_adr_i == `MPS_A_CMPT)
				wb_dat_o <= cmpt_ff;
			else if (wb_adr_i == `MPS_A_STAT)
				wb_dat_o <= stat;
			else if (wb_adr_i == `MPS_A_THERM)
				wb_dat_o <= acc_ff[55:24];
			else if (wb_adr_i == `MPS_A_FLTA)
				wb_dat_o <= {16'h0, flt_ff[0]};
			else if (wb_adr_i == `MPS_A_FLTB)
				wb_dat_o <= {16'h0, flt_ff[1]};
			else if (wb_adr_i == `MPS_A_FLTC)
				wb_dat_o <= {16'h0, flt_ff[2]};
			else if (wb_adr_i == `MPS_A_HIST)
				wb_dat_o <= {hist_ff[3], hist_ff[2], hist_ff[1], hist_ff[0]};
			else
				wb_dat_o <= 32'h0000_0000;
		end
	end
endmodule // mps_top
`default_nettype wire

// *** testbench/mps_plant.sv ***
/* Far-side model: phase currents through the contactor, phase signs, flow switch.
   Assumes clk_sys from the bench; load and flow level are set by the bench. */
`default_nettype none
module mps_plant (
	input wire logic clk_sys,
	input wire logic main_contactor,
	input wire logic flow_en,
	input wire logic [15:0] load,
	output logic [15:0] cur_a,
	output logic [15:0] cur_b,
	output logic [15:0] cur_c,
	output logic sign_a,
	output logic sign_b,
	output logic sign_c,
	output logic flow_sw
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] ph_ff = 5'h00;
	logic [4:0] nxt_ph;
	// Thirty-cycle mains period
	assign nxt_ph = (ph_ff == 5'h1D) ? 5'h00 : ph_ff + 5'h01;
	always @(posedge clk_sys)
		ph_ff <= nxt_ph;
	// Phases rise in order A, B, C
	assign sign_a = ph_ff < 5'h0F;
	assign sign_b = ph_ff >= 5'h0A && ph_ff < 5'h19;
	assign sign_c = ph_ff >= 5'h14 || ph_ff < 5'h05;
	// Current flows only through a closed contactor
	assign cur_a = main_contactor ? load : 16'h0000;
	assign cur_b = main_contactor ? load : 16'h0000;
	assign cur_c = main_contactor ? load : 16'h0000;
	// Switch follows the bench's flow level
	assign flow_sw = flow_en;
endmodule // mps_plant
`default_nettype wire

// *** testbench/mps_asserts.sv ***
/* Checker on the sequencer top ports.
   Bound into mps_top; one clock, synchronous active-low reset. */
`default_nettype none
module mps_asserts (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic ext_trip2,
	input wire logic main_contactor,
	input wire logic fault_out,
	input wire logic flow_timeout_message,
	input wire logic ext_trip_message
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// Clocking and steps
	// ----------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// Request taken at this edge
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Trip pin raised and held long enough to be seen
	sequence s_ext;
		$rose(ext_trip2) ##1 ext_trip2 [*3];
	endsequence
	// ----------------
	// Properties
	// ----------------
	ack_next_a: assert property (s_req |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero while idle");
	ext_seen_a: assert property (s_ext |-> ##[0:4] (ext_trip_message && fault_out))
		else $error("external trip not latched");
	ext_hold_a: assert property ((ext_trip2 [*4] ##0 ext_trip_message) |=> ext_trip_message)
		else $error("external trip released while pin high");
	trip_open_a: assert property ($rose(fault_out) |-> ##[0:2] !main_contactor)
		else $error("contactor still closed after trip");
	close_clean_a: assert property ($rose(main_contactor) |-> !fault_out)
		else $error("contactor closed with fault latched");
	flow_open_a: assert property (flow_timeout_message |-> !main_contactor)
		else $error("contactor closed during flow timeout");
endmodule // mps_asserts
bind mps_top mps_asserts u_chk (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
	.ext_trip2, .main_contactor, .fault_out, .flow_timeout_message, .ext_trip_message);
`default_nettype wire

// *** testbench/tb_top.sv ***
/* Self-checking bench for the motor protection sequencer.
   Assumes mps_defs.vh on the include path and mps_plant as far side. */
`include "mps_defs.vh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 5;
	logic clk_sys = 1'h0, nrst = 1'h0;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
	logic wb_ack_o, main_contactor, fault_out, flow_timeout_message, ext_trip_message;
	logic [15:0] cur_a, cur_b, cur_c, disp_value, baud_div, load = 16'h0064;
	logic [11:0] zero_sequence_sensor = 12'h000;
	logic sign_a, sign_b, sign_c, flow_sw, disp_history, flow_en = 1'h0;
	logic on_cmd = 1'h0, off_cmd = 1'h0, ext_trip2 = 1'h0;
	logic key_up = 1'h0, key_down = 1'h0, escape_key = 1'h0, enter_key = 1'h0;
	logic [7:0] ra [4] = '{`MPS_A_CTRL, `MPS_A_ISET, `MPS_A_OLT, `MPS_A_GF};
	logic [31:0] rv [4] = '{`MPS_R_CTRL, `MPS_R_ISET, `MPS_R_OLT, `MPS_R_GF};
	int err_count = 0, samples_checked = 0;
	// Design and far side
	mps_top #(.MS_CYC(MS)) dut (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cur_a, .cur_b, .cur_c,
		.zero_sequence_sensor, .sign_a, .sign_b, .sign_c, .on_cmd, .off_cmd, .flow_sw,
		.ext_trip2, .key_up, .key_down, .escape_key, .enter_key, .main_contactor, .fault_out,
		.flow_timeout_message, .ext_trip_message, .disp_value, .disp_history, .baud_div);
	mps_plant u_plant (.clk_sys, .main_contactor, .flow_en, .load, .cur_a, .cur_b, .cur_c,
		.sign_a, .sign_b, .sign_c, .flow_sw);
	// 250 MHz clock
	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end
	// ----------------
	// Report and compare
	// ----------------
	task conclude;
		$display("compares %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_rng(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask
	// ----------------
	// Bus and pin helpers
	// ----------------
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (wb_ack_o !== 1'h1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		if (wb_ack_o !== 1'h1)
		begin
			err_count++;
			conclude;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'h1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'h0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: pick = main_contactor;
			1: pick = fault_out;
			2: pick = flow_timeout_message;
			default: pick = disp_history;
		endcase
	endfunction
	// Cycles until an output reaches a level, bounded
	task measure(input int w, input logic lvl, input int lo, input int hi);
		int n;
		n = 0;
		while (pick(w) !== lvl && n <= hi + 8)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n > hi + 8)
		begin
			err_count++;
			conclude;
		end
		else
			chk_rng(n, lo, hi);
	endtask
	task meas_ms(input int w, input logic lvl, input int ms);
		measure(w, lvl, ms * MS - 20, ms * MS + 20);
	endtask
	task cmd(input logic is_off);
		on_cmd <= !is_off;
		off_cmd <= is_off;
		repeat (4) @(posedge clk_sys);
		on_cmd <= 1'h0;
		off_cmd <= 1'h0;
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		repeat (3) @(posedge clk_sys);
		nrst <= 1'h1;
		for (int i = 0; i < 4; i++)
			rd(ra[i], rv[i]);
		chk({16'h0000, baud_div}, 32'h0000_65B9);
		wr(`MPS_A_CTRL, 32'h0000_0100);
		repeat (2) @(posedge clk_sys);
		chk({16'h0000, baud_div}, 32'h0000_32DC);
		wr(`MPS_A_CTRL, 32'h0000_0200);
		repeat (2) @(posedge clk_sys);
		chk({16'h0000, baud_div}, 32'h0000_196E);
		wr(8'hFC, 32'hFFFF_FFFF);
		rd(8'hFC, 32'h0000_0000);
		// External trip latches until pin gone and reset written
		cmd(1'h0);
		measure(0, 1'h1, 0, 8);
		ext_trip2 <= 1'h1;
		measure(1, 1'h1, 0, 8);
		chk({31'h0, ext_trip_message}, 32'h0000_0001);
		rd(`MPS_A_STAT, 32'h0000_0940);
		wr(`MPS_A_CTRL, 32'h0000_1000);
		chk({31'h0, fault_out}, 32'h0000_0001);
		ext_trip2 <= 1'h0;
		repeat (8) @(posedge clk_sys);
		chk({31'h0, fault_out}, 32'h0000_0001);
		wr(`MPS_A_CTRL, 32'h0000_1000);
		repeat (3) @(posedge clk_sys);
		chk({30'h0, fault_out, ext_trip_message}, 32'h0000_0000);
		// Ground fault trips after its 50 ms delay
		wr(`MPS_A_CTRL, 32'h0000_0008);
		zero_sequence_sensor <= 12'h0C8;
		meas_ms(1, 1'h1, 50);
		zero_sequence_sensor <= 12'h000;
		wr(`MPS_A_CTRL, 32'h0000_1000);
		// Under-current, then overload at six times set current
		wr(`MPS_A_CTRL, 32'h0000_0010);
		load <= 16'h0028;
		cmd(1'h0);
		measure(0, 1'h1, 0, 8);
		meas_ms(1, 1'h1, 3000);
		rd(`MPS_A_FLTB, 32'h0000_0028);
		wr(`MPS_A_CTRL, 32'h0000_1000);
		wr(`MPS_A_OLT, 32'h003C_C801);
		load <= 16'h0258;
		cmd(1'h0);
		meas_ms(1, 1'h1, 1000);
		load <= 16'h0064;
		repeat (20) @(posedge clk_sys);
		wr(`MPS_A_CTRL, 32'h0000_1000);
		chk({31'h0, fault_out}, 32'h0000_0000);
		// Time-delay mode, one second each way
		wr(`MPS_A_CTRL, 32'h0000_0020);
		wr(`MPS_A_SEQT, 32'h0001_0001);
		rd(`MPS_A_SEQT, 32'h0001_0001);
		cmd(1'h0);
		meas_ms(0, 1'h1, 1000);
		cmd(1'h1);
		meas_ms(0, 1'h0, 1000);
		// Flow mode: timeout, start, loss and return, stop
		wr(`MPS_A_CTRL, 32'h0000_0040);
		wr(`MPS_A_CMPT, 32'h0000_0002);
		cmd(1'h0);
		meas_ms(2, 1'h1, 2000);
		flow_en <= 1'h1;
		cmd(1'h0);
		meas_ms(0, 1'h1, 1000);
		chk({31'h0, flow_timeout_message}, 32'h0000_0000);
		flow_en <= 1'h0;
		measure(0, 1'h0, 0, 8);
		repeat (200) @(posedge clk_sys);
		flow_en <= 1'h1;
		meas_ms(0, 1'h1, 1000);
		cmd(1'h1);
		meas_ms(0, 1'h0, 1000);
		// History view on escape plus enter
		escape_key <= 1'h1;
		enter_key <= 1'h1;
		measure(3, 1'h1, 0, 8);
		chk({16'h0000, disp_value}, 32'h0000_0001);
		key_up <= 1'h1;
		repeat (6) @(posedge clk_sys);
		chk({16'h0000, disp_value}, 32'h0000_0002);
		key_up <= 1'h0;
		key_down <= 1'h1;
		repeat (6) @(posedge clk_sys);
		chk({16'h0000, disp_value}, 32'h0000_0001);
		escape_key <= 1'h0;
		enter_key <= 1'h0;
		repeat (6) @(posedge clk_sys);
		chk({15'h0000, disp_history, disp_value}, 32'h0000_0258);
		conclude;
	end
endmodule // tb_top
`default_nettype wire
